// >>> logic/vr_ctrl.sv
// Function
// - Bit 7 powers the reference ladder on when set, down when clear.
// - Bit 6 routes the reference level onto the shared analog pin.
// - Pin output enable overrides port A direction bit 2 for that pin.
// - Bit 5 set gives code/24 of span; clear gives 1/4 plus code/32.
// - Bit 4 set takes span from external reference pins, clear from supply.
// - Bits 3 to 0 hold a 4-bit level code choosing one of sixteen taps.
// - Reset clears the register: powered down, disconnected, high range, code zero.
// - Wake from sleep leaves every control bit unchanged.
// - Reference enable and output work regardless of comparator configuration.
// - Reference reaches both comparator non-inverting inputs only in mode 110.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "vr_regs.svh"

module vr_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] comparator_mode_select,
	input wire logic port_a_direction_2,
	input wire logic sleep_wake,
	output vr_pkg::vr_ctrl_t ladder_ctrl_q,
	output logic ref_to_comparator_q,
	output logic shared_pin_dir_q,
	output logic shared_ref_pin_connect_q,
	output logic [6:0] level_num_q
);

	// ****************************************
	// State
	// ****************************************
	vr_pkg::vr_ctrl_t ctrl_q;
	vr_pkg::vr_ctrl_t ctrl_d;
	vr_pkg::vr_ctrl_t ladder_ctrl_d;
	vr_pkg::vr_apb_rsp_t rsp_q;
	vr_pkg::vr_apb_rsp_t rsp_d;
	vr_pkg::vr_status_t status;
	logic ref_to_comparator_d;
	logic access;
	logic do_write;
	logic do_read;

	// ****************************************
	// Address decode helpers
	// ****************************************
	function automatic logic vr_hit_ctrl(input logic [7:0] addr);
		vr_hit_ctrl = (addr == `VR_CTRL_OFFSET);
	endfunction

	function automatic logic vr_hit_status(input logic [7:0] addr);
		vr_hit_status = (addr == `VR_STATUS_OFFSET);
	endfunction

	// ****************************************
	// APB handshake
	// ****************************************
	// One wait state: pready rises in the second access cycle, which keeps
	// every response bit straight from a flop at the cost of one cycle.
	always_comb begin
		access = psel && penable;
		do_write = access && rsp_q.pready && pwrite;
		do_read = access && !rsp_q.pready && !pwrite;
	end

	// Status word as software sees it
	always_comb begin
		status.level_num = level_num_q;
		status.ref_to_cmp = ref_to_comparator_q;
		status.pin_analog = shared_ref_pin_connect_q;
	end

	// Response next values; read data and error are set with pready
	always_comb begin
		rsp_d.pready = access && !rsp_q.pready;
		rsp_d.prdata = 32'h0000_0000;
		rsp_d.pslverr = 1'b0;
		if (access && !rsp_q.pready) begin
			if (vr_hit_ctrl(paddr)) begin
				if (do_read) begin
					rsp_d.prdata = {24'h00_0000, ctrl_q};
				end
			end else if (vr_hit_status(paddr)) begin
				if (do_read) begin
					rsp_d.prdata = {23'h00_0000, status};
				end
			end else begin
				rsp_d.pslverr = 1'b1;
			end
		end
	end

	// Register the response
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_q <= '0;
		end else begin
			rsp_q <= rsp_d;
		end
	end

	// Bus outputs taken straight from the response flops
	always_comb begin
		prdata = rsp_q.prdata;
		pready = rsp_q.pready;
		pslverr = rsp_q.pslverr;
	end

	// ****************************************
	// Control register
	// ****************************************
	// Only a bus write changes it; sleep_wake is deliberately not read here,
	// so leaving sleep keeps the settings the software left behind.
	always_comb begin
		ctrl_d = ctrl_q;
		if (do_write && vr_hit_ctrl(paddr)) begin
			ctrl_d = vr_pkg::vr_ctrl_t'(pwdata[7:0]);
		end
	end

	// Register with reset to all zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `VR_CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ****************************************
	// Ladder controls and comparator routing
	// ****************************************
	// Ladder settings follow the register with no comparator gating
	always_comb begin
		ladder_ctrl_d.power = ctrl_d.power;
		ladder_ctrl_d.pin_oe = ctrl_d.pin_oe;
		ladder_ctrl_d.range_low = ctrl_d.range_low;
		ladder_ctrl_d.source_ext = ctrl_d.source_ext;
		ladder_ctrl_d.code = ctrl_d.code;
		ref_to_comparator_d = (comparator_mode_select == `VR_CMP_MODE_INT_REF);
	end

	// Outputs to the analog side, updated on the write edge itself
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ladder_ctrl_q <= `VR_CTRL_RESET;
			ref_to_comparator_q <= 1'b0;
		end else begin
			ladder_ctrl_q <= ladder_ctrl_d;
			ref_to_comparator_q <= ref_to_comparator_d;
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	// Level lags the ladder by a cycle; the analog settling dwarfs it anyway
	vr_level_calc u_level (
		.pclk(pclk),
		.presetn(presetn),
		.ctrl(ctrl_q),
		.level_num_q(level_num_q)
	);

	// Shared pin direction and reference connection
	vr_pin_mux u_pin (
		.pclk(pclk),
		.presetn(presetn),
		.pin_oe(ctrl_q.pin_oe),
		.port_a_direction_2(port_a_direction_2),
		.pin_dir_eff_q(shared_pin_dir_q),
		.pin_ref_connect_q(shared_ref_pin_connect_q)
	);

	// ****************************************
	// Checks
	// ****************************************
	sequence s_ctrl_write;
		psel && penable && pwrite && pready && paddr == `VR_CTRL_OFFSET;
	endsequence

	sequence s_ctrl_read;
		psel && penable && !pwrite && !pready && paddr == `VR_CTRL_OFFSET;
	endsequence

	ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_ctrl_write |=> ctrl_q == $past(pwdata[7:0]) && ladder_ctrl_q == $past(pwdata[7:0]))
		else $error("control write not applied on the write edge");

	ctrl_readback_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_ctrl_read |=> pready && prdata == {24'h00_0000, $past(ctrl_q)})
		else $error("control read back differs");

	ctrl_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(psel && penable && pwrite && pready) |=> $stable(ctrl_q))
		else $error("control changed without a write");

	wake_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		sleep_wake && !(psel && pwrite) |=> ctrl_q == $past(ctrl_q))
		else $error("wake disturbed control bits");

	reset_clear_a: assert property (@(posedge pclk)
		!presetn |-> ctrl_q == 8'h00 && ladder_ctrl_q == 8'h00 && !ref_to_comparator_q)
		else $error("reset did not clear control");

	power_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		ladder_ctrl_q.power == ctrl_q.power && ladder_ctrl_q.source_ext == ctrl_q.source_ext)
		else $error("ladder power or source differs from register");

	cmp_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		comparator_mode_select == 3'h6 |=> ref_to_comparator_q ##1
		(ref_to_comparator_q == ($past(comparator_mode_select) == 3'h6)))
		else $error("reference routed in wrong comparator mode");

	cmp_indep_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_ctrl_write ##0 (comparator_mode_select != 3'h6 && pwdata[7]) |=> ladder_ctrl_q.power)
		else $error("reference enable gated by comparator mode");

	pready_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready |=> pready)
		else $error("access not answered in one wait state");

	unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready && paddr != 8'h00 && paddr != 8'h04 |=> pslverr && pready)
		else $error("unmapped address not flagged");

	// ****************************************
	// Response shape checks
	// ****************************************
	// The response flops must stay quiet between answers, or a master that
	// samples prdata without pready would pick up stale data.
	sequence s_status_read;
		psel && penable && !pwrite && !pready && paddr == `VR_STATUS_OFFSET;
	endsequence

	sequence s_other_write;
		psel && penable && pwrite && pready && paddr != `VR_CTRL_OFFSET;
	endsequence

	// One-cycle answers let the next setup follow straight after
	ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("pready held for more than one cycle");

	err_with_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("error flagged without pready");

	idle_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> prdata == 32'h0000_0000 && !pslverr)
		else $error("response bits set between answers");

	status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_status_read |=> pready && !pslverr && prdata == {23'h00_0000, $past(status)})
		else $error("status read back differs");

	ctrl_read_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_ctrl_read |=> !pslverr)
		else $error("control read flagged as error");

	status_write_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pwrite && !pready && paddr == `VR_STATUS_OFFSET
		|=> pready && !pslverr)
		else $error("status write flagged as error");

	// ****************************************
	// Routing and retention checks
	// ****************************************
	// A write that misses the control word must leave the ladder alone
	other_write_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_other_write |=> $stable(ctrl_q) && $stable(ladder_ctrl_q))
		else $error("control changed by a write elsewhere");

	// Routing depends on the mode alone, never on the power bit
	route_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		comparator_mode_select != 3'h6 |=> !ref_to_comparator_q)
		else $error("reference routed outside its comparator mode");

	// Powering down must work in the routing mode too
	power_down_indep_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_ctrl_write ##0 (comparator_mode_select == 3'h6 && !pwdata[7])
		|=> !ladder_ctrl_q.power)
		else $error("reference power-down gated by comparator mode");

	// Retention is free: nothing but a bus write ever loads these flops
	wake_ladder_a: assert property (@(posedge pclk) disable iff (!presetn)
		sleep_wake && !(psel && pwrite) |=> $stable(ladder_ctrl_q))
		else $error("wake disturbed ladder settings");

	// Pin and level outputs must sit at their safe values during reset
	reset_pins_a: assert property (@(posedge pclk)
		!presetn |-> shared_pin_dir_q && !shared_ref_pin_connect_q
		&& level_num_q == `VR_HIGH_BASE && !pready && !pslverr)
		else $error("reset left pin, level or bus outputs set");

endmodule // vr_ctrl

// >>> logic/vr_regs.svh
`ifndef VR_REGS_SVH
`define VR_REGS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define VR_CTRL_OFFSET 8'h00
`define VR_STATUS_OFFSET 8'h04

// ****************************************
// Control register fields and reset
// ****************************************
`define VR_POWER_BIT 7
`define VR_PIN_OE_BIT 6
`define VR_RANGE_BIT 5
`define VR_SOURCE_BIT 4
`define VR_CODE_MSB 3
`define VR_CODE_LSB 0
`define VR_CTRL_RESET 8'h00

// ****************************************
// Comparator mode that routes the reference
// ****************************************
`define VR_CMP_MODE_INT_REF 3'h6

// ****************************************
// Level arithmetic, in 96ths of the span
// ****************************************
`define VR_LOW_STEP 7'h04
`define VR_HIGH_BASE 7'h18
`define VR_HIGH_STEP 7'h03

`endif

// >>> logic/vr_pkg.sv
package vr_pkg;

	// Control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic power;
		logic pin_oe;
		logic range_low;
		logic source_ext;
		logic [3:0] code;
	} vr_ctrl_t;

	// Status register layout, low bits of the word
	typedef struct packed {
		logic [6:0] level_num;
		logic ref_to_cmp;
		logic pin_analog;
	} vr_status_t;

	// APB response carried back to the master
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} vr_apb_rsp_t;

endpackage

// >>> logic/vr_level_calc.sv
`timescale 1ns/100ps
`include "vr_regs.svh"

module vr_level_calc (
	input wire logic pclk,
	input wire logic presetn,
	input wire vr_pkg::vr_ctrl_t ctrl,
	output logic [6:0] level_num_q
);

	logic [6:0] level_num_d;

	// ****************************************
	// Tap level in 96ths of the source span
	// ****************************************
	function automatic logic [6:0] vr_level(input logic range_low, input logic [3:0] code);
		logic [6:0] c;
		c = {3'h0, code};
		if (range_low) begin
			vr_level = 7'(c * `VR_LOW_STEP); // code/24 of span
		end else begin
			vr_level = 7'(`VR_HIGH_BASE + c * `VR_HIGH_STEP); // 1/4 + code/32
		end
	endfunction

	// Next level from the range and the code
	always_comb begin
		level_num_d = vr_level(ctrl.range_low, ctrl.code);
	end

	// Register the level for the ladder tap select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_num_q <= 7'h18;
		end else begin
			level_num_q <= level_num_d;
		end
	end

	level_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl.range_low |=> level_num_q == 7'($past(ctrl.code) * 4))
		else $error("low range level wrong");

	level_high_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl.range_low |=> level_num_q == 7'(24 + $past(ctrl.code) * 3))
		else $error("high range level wrong");

endmodule // vr_level_calc

// >>> logic/vr_pin_mux.sv
`timescale 1ns/100ps

module vr_pin_mux (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin_oe,
	input wire logic port_a_direction_2,
	output logic pin_dir_eff_q,
	output logic pin_ref_connect_q
);

	logic pin_dir_eff_d;
	logic pin_ref_connect_d;

	// ****************************************
	// Shared pin direction override
	// ****************************************
	// Routing the reference forces the digital driver off, whatever the port says
	always_comb begin
		pin_ref_connect_d = pin_oe;
		pin_dir_eff_d = pin_oe ? 1'b1 : port_a_direction_2;
	end

	// Register both pin controls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_dir_eff_q <= 1'b1;
			pin_ref_connect_q <= 1'b0;
		end else begin
			pin_dir_eff_q <= pin_dir_eff_d;
			pin_ref_connect_q <= pin_ref_connect_d;
		end
	end

	pin_override_a: assert property (@(posedge pclk) disable iff (!presetn)
		pin_oe |=> pin_dir_eff_q && pin_ref_connect_q)
		else $error("pin output enable did not override direction");

	pin_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		!pin_oe |=> !pin_ref_connect_q && pin_dir_eff_q == $past(port_a_direction_2))
		else $error("pin not returned to port direction");

endmodule // vr_pin_mux

// >>> testbench/tb.sv
`timescale 1ns/100ps

module tb;
	typedef struct packed {
		logic rd;
		logic [31:0] d;
		logic e;
	} vr_exp_t;

	logic pclk = 1'b0;
	logic presetn = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [2:0] mode = 3'h0;
	logic dir2 = 1'b1;
	logic wake = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	vr_pkg::vr_ctrl_t ladder_ctrl_q;
	logic ref_cmp;
	logic pin_dir;
	logic pin_conn;
	logic [6:0] level_num_q;
	int num_errors = 0;
	int total_checks = 0;
	int seed = 61;
	vr_exp_t exp_q[$];
	vr_exp_t e;
	logic [7:0] c;

	// ****************************************
	// Clock, device and checks
	// ****************************************
	always #25 pclk = ~pclk;

	vr_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .comparator_mode_select(mode),
		.port_a_direction_2(dir2), .sleep_wake(wake), .ladder_ctrl_q(ladder_ctrl_q),
		.ref_to_comparator_q(ref_cmp), .shared_pin_dir_q(pin_dir),
		.shared_ref_pin_connect_q(pin_conn), .level_num_q(level_num_q));

	task summarize;
		if (num_errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Level in 96ths: low range code*4, high range 24+code*3
	function automatic logic [6:0] lvl(input logic [7:0] v);
		lvl = v[5] ? {1'b0, v[3:0], 2'b00} : 7'h18 + {3'h0, v[3:0]} * 7'h03;
	endfunction

	// Status word as the monitor expects it
	function automatic logic [31:0] stat(input logic [7:0] v);
		stat = {23'h0, lvl(v), mode == 3'h6, v[6]};
	endfunction

	// One APB transfer; the bounded wait guards against a dead slave
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] xd, input logic xe);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		exp_q.push_back({~wr, xd, xe});
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			num_errors++;
			summarize();
		end else begin
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	// Monitor: oldest note meets each answer
	always @(posedge pclk) begin
		if (pready === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk(32'h1, 32'h0);
			end else begin
				e = exp_q.pop_front();
				chk({31'h0, pslverr}, {31'h0, e.e});
				if (e.rd) begin
					chk(prdata, e.d);
				end
			end
		end
	end

	// Write control, then check ladder, pin and level outputs
	task wr_chk(input logic [31:0] d);
		c = d[7:0];
		apb(1'b1, 8'h00, d, 32'h0, 1'b0);
		// Ladder flops load in the write edge's own time step
		#1;
		chk({24'h0, ladder_ctrl_q}, {24'h0, c});
		@(posedge pclk);
		#1;
		chk({31'h0, pin_conn}, {31'h0, c[6]});
		chk({31'h0, pin_dir}, {31'h0, c[6] | dir2});
		chk({25'h0, level_num_q}, {25'h0, lvl(c)});
		apb(1'b0, 8'h00, 32'h0, {24'h0, c}, 1'b0);
		apb(1'b0, 8'h04, 32'h0, stat(c), 1'b0);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		// Drop reset at time zero so every flop is known at the first edge
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h00, 32'h0, 32'h0, 1'b0);
		apb(1'b0, 8'h04, 32'h0, 32'h60, 1'b0);
		for (int i = 0; i < 24; i++) begin
			@(posedge pclk);
			dir2 <= 1'($random(seed));
			wr_chk($random(seed));
		end
		wr_chk(32'hffff_ff2f);
		wr_chk(32'h0000_00c5);
		// Every comparator mode, ladder powered down
		wr_chk(32'h0000_0040);
		for (int m = 0; m < 8; m++) begin
			@(posedge pclk);
			mode <= m[2:0];
			@(posedge pclk);
			#1;
			chk({31'h0, ref_cmp}, {31'h0, m == 6});
			if (m == 6) begin
				wr_chk(32'h0000_0040);
			end
		end
		// Refused and ignored accesses
		apb(1'b1, 8'h08, 32'h0000_00ff, 32'h0, 1'b1);
		apb(1'b0, 8'h08, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 8'h04, 32'h0000_00ff, 32'h0, 1'b0);
		apb(1'b0, 8'h00, 32'h0, 32'h40, 1'b0);
		// Wake pulse leaves the register alone
		// Power cleared before sleep, as software should
		wr_chk(32'h0000_0039);
		@(posedge pclk);
		wake <= 1'b1;
		@(posedge pclk);
		wake <= 1'b0;
		repeat (2) @(posedge pclk);
		apb(1'b0, 8'h00, 32'h0, 32'h0000_0039, 1'b0);
		// Reset in mid-run returns every output to its reset value
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
		chk({24'h0, ladder_ctrl_q}, 32'h0);
		chk({31'h0, pin_conn}, 32'h0);
		chk({31'h0, pin_dir}, 32'h1);
		chk({25'h0, level_num_q}, 32'h18);
		chk({31'h0, ref_cmp}, 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h00, 32'h0, 32'h0, 1'b0);
		repeat (2) @(posedge pclk);
		chk(exp_q.size(), 32'h0);
		summarize();
	end

	// Watchdog well beyond the expected run
	initial begin
		#(4000 * 50);
		num_errors++;
		summarize();
	end
endmodule // tb
